// file: ddi_pkg.sv
/*
  Constants and types for the drive digital input decoder.
  Assumes a single 10 MHz control clock and an active-low asynchronous reset.
*/
package ddi_pkg;
  localparam logic [7:0] EXT_TRIP_CODE      = 8'h33;  // 51
  localparam logic [4:0] REF_SEL_AI_SWITCH  = 5'h0E;  // 14
  localparam int         SYNC_STAGES        = 2;
  localparam real        FEEDBACK_TIME_MS   = 100.0;
  localparam real        CLOCK_MHZ          = 10.0;
  localparam int         FEEDBACK_CYCLES    = int'(FEEDBACK_TIME_MS * CLOCK_MHZ * 1000.0);
  localparam logic [1:0] SRC_TERMINAL       = 2'h0;
  localparam logic [1:0] SRC_PANEL          = 2'h1;
  localparam logic [1:0] SRC_NETWORK        = 2'h2;
  localparam logic [2:0] RESET_PRESET       = 3'h0;

  typedef enum logic [1:0] {
    DDI_BANK_IDLE,
    DDI_BANK_LOAD,
    DDI_BANK_SAVE
  } ddi_bank_t;

  typedef enum {
    DDI_LINK_DRIVE,
    DDI_LINK_SYNC,
    DDI_LINK_DIRECT
  } ddi_link_t;
endpackage : ddi_pkg

// file: ddi_sync.sv
/*
  Two flip-flop synchroniser for a vector of contact inputs.
  Assumes inputs are asynchronous to clock.
*/
`timescale 1ns/10ps
module ddi_sync
  import ddi_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  initial begin
    if (WIDTH < 1) $error("ddi_sync width must be positive");
  end

  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } ddi_sync_state_t;

  ddi_sync_state_t state;
  ddi_sync_state_t next_state;

  always_comb begin
    next_state.first  = async_in;
    next_state.second = state.first;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign sync_out = state.second;
endmodule : ddi_sync

// file: ddi_edge.sv
/*
  Rising and falling edge detector on already synchronised levels.
  Assumes inputs are on the clock domain.
*/
`timescale 1ns/10ps
module ddi_edge
  import ddi_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise,
  output logic      [WIDTH-1:0] fall
);
  initial begin
    if (WIDTH < 1) $error("ddi_edge width must be positive");
  end

  typedef struct packed {
    logic [WIDTH-1:0] last;
  } ddi_edge_state_t;

  ddi_edge_state_t state;
  ddi_edge_state_t next_state;

  always_comb begin
    next_state.last = level;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign rise = level & ~state.last;
  assign fall = ~level & state.last;
endmodule : ddi_edge

// file: ddi_decoder.sv
/*
  Drive digital input decoder: turns contact levels into internal commands.
  Assumes contacts are asynchronous; config and status levels come from
  logic on the same clock (run state, stored source, reference selection).
*/
`timescale 1ns/10ps
module ddi_decoder
  import ddi_pkg::*;
#(
  parameter int FEEDBACK_DELAY = FEEDBACK_CYCLES
) (
  input  wire logic       clock,
  input  wire logic       rst_b,
  // contact pins
  input  wire logic [2:0] preset_in,
  input  wire logic       pot_down_in,
  input  wire logic       pot_up_in,
  input  wire logic       trip_clear_in,
  input  wire logic       ext_trip_no_in,
  input  wire logic       ext_trip_nc_in,
  input  wire logic       ramp_set_in,
  input  wire logic       ramp_hold_in,
  input  wire logic       dc_braking_request,
  input  wire logic       jog_in,
  input  wire logic       ref_source_in,
  input  wire logic [2:0] force_src_in,
  input  wire logic       settings_bank_select,
  input  wire logic       control_mode_select,
  input  wire logic       inch_enable_in,
  input  wire logic [1:0] inch_in,
  input  wire logic       quick_stop_in,
  input  wire logic       supply_ack_in,
  input  wire logic       sync_request_in,
  input  wire logic       transfer_request_in,
  input  wire logic       transfer_reset_in,
  input  wire logic       conv_contactor_fb_in,
  input  wire logic       line_contactor_fb_in,
  input  wire logic       motor_select_bit0,
  input  wire logic       motor_select_bit1,
  input  wire logic       motor_select_bit2,
  // same-clock configuration and status
  input  wire logic       hold_allows_decel_option,
  input  wire logic       motor_running,
  input  wire logic       motor_stopped,
  input  wire logic       start_active,
  input  wire logic       other_run_request,
  input  wire logic [1:0] stored_source,
  input  wire logic [4:0] ref_selection,
  input  wire logic       multi_motor_mode,
  input  wire logic       sync_complete,
  // commands
  output logic      [2:0] preset_index,
  output logic            pot_decrease,
  output logic            pot_increase,
  output logic            trip_clear,
  output logic            ext_trip,
  output logic      [7:0] ext_trip_code,
  output logic            ramp_set_two,
  output logic            ramp_hold,
  output logic            ramp_hold_decel_ok,
  output logic            dc_braking,
  output logic            jog_select,
  output logic            ref_use_ai,
  output logic            ref_alternate,
  output logic      [1:0] active_source,
  output logic            source_forced,
  output logic            bank_load,
  output logic            bank_save,
  output logic            control_mode_two,
  output logic            inch_start,
  output logic      [1:0] inch_ref_select,
  output logic            quick_stop,
  output logic            supply_switch_trip,
  output logic            sync_active,
  output logic            conv_contactor_cmd,
  output logic            line_contactor_cmd,
  output logic            contactor_feedback_trip,
  output logic      [3:0] motor_number
);
  localparam int NPIN = 31;
  localparam int FB_W = $clog2(FEEDBACK_DELAY + 1);

  initial begin
    if (FEEDBACK_DELAY < 1) $error("feedback delay must be at least one cycle");
  end

  logic [NPIN-1:0] pins_raw;
  logic [NPIN-1:0] pins;
  logic [NPIN-1:0] pins_rise;

  // one contact per line, highest bit first; the slices below must track this order
  assign pins_raw = {
    preset_in,             // 30:28
    pot_down_in,
    pot_up_in,
    trip_clear_in,         // 25
    ext_trip_no_in,
    ext_trip_nc_in,
    ramp_set_in,
    ramp_hold_in,
    dc_braking_request,
    jog_in,
    ref_source_in,         // 18
    force_src_in,          // 17:15
    settings_bank_select,
    control_mode_select,
    inch_enable_in,
    inch_in,               // 11:10
    quick_stop_in,
    supply_ack_in,
    sync_request_in,
    transfer_request_in,
    transfer_reset_in,
    conv_contactor_fb_in,
    line_contactor_fb_in,  // 3
    motor_select_bit2,
    motor_select_bit1,
    motor_select_bit0      // 0
  };

  ddi_sync #(.WIDTH(NPIN)) u_sync (
    .clock    (clock),
    .rst_b    (rst_b),
    .async_in (pins_raw),
    .sync_out (pins)
  );

  ddi_edge #(.WIDTH(NPIN)) u_edge (
    .clock (clock),
    .rst_b (rst_b),
    .level (pins),
    .rise  (pins_rise),
    .fall  ()
  );

  logic [2:0] s_preset;
  logic       s_down, s_up, s_noc, s_ncc, s_rset, s_hold, s_dcb, s_jog, s_refsrc;
  logic [2:0] s_force;
  logic       s_bank, s_mode, s_inen;
  logic [1:0] s_inch;
  logic       s_qs, s_ack, s_syncreq, s_xfer, s_xrst, s_convfb, s_linefb;
  logic [2:0] s_motor;
  logic       clear_edge;

  assign {s_preset, s_down, s_up} = pins[30:26];
  assign {s_noc, s_ncc, s_rset, s_hold, s_dcb, s_jog, s_refsrc} = pins[24:18];
  assign {s_force, s_bank, s_mode, s_inen, s_inch} = pins[17:10];
  assign {s_qs, s_ack, s_syncreq, s_xfer, s_xrst, s_convfb, s_linefb} = pins[9:3];
  assign s_motor    = pins[2:0];
  assign clear_edge = pins_rise[25];

  typedef struct packed {
    logic [2:0]      preset_index;
    logic            pot_decrease;
    logic            pot_increase;
    logic            trip_clear;
    logic            ext_trip;
    logic [7:0]      ext_trip_code;
    logic            ramp_set_two;
    logic            ramp_hold;
    logic            ramp_hold_decel_ok;
    logic            dc_braking;
    logic            jog_select;
    logic            ref_use_ai;
    logic            ref_alternate;
    logic [1:0]      active_source;
    logic            source_forced;
    ddi_bank_t       bank;
    logic            bank_load;
    logic            bank_save;
    logic            control_mode_two;
    logic            inch_start;
    logic [1:0]      inch_ref_select;
    logic            quick_stop;
    logic            supply_switch_trip;
    ddi_link_t       link;
    logic            sync_active;
    logic            conv_cmd;
    logic            line_cmd;
    logic [FB_W-1:0] fb_count;
    logic            fb_trip;
    logic [3:0]      motor_number;
  } ddi_state_t;

  ddi_state_t state;
  ddi_state_t next_state;

  always_comb begin
    next_state = state;
    next_state.preset_index = s_preset;
    next_state.pot_decrease = s_down;
    next_state.pot_increase = s_up & ~s_down;
    next_state.trip_clear   = clear_edge;
    next_state.ext_trip     = s_noc | ~s_ncc;
    next_state.ramp_set_two = s_rset;
    next_state.ramp_hold    = s_hold;
    next_state.ramp_hold_decel_ok = s_hold & hold_allows_decel_option;
    next_state.dc_braking   = s_dcb & motor_stopped;
    next_state.jog_select   = s_jog;
    next_state.ref_use_ai    = (ref_selection == REF_SEL_AI_SWITCH);
    next_state.ref_alternate = s_refsrc;
    // terminal override ranks highest, then panel, then network
    next_state.source_forced = |s_force;
    if (s_force[0]) begin
      next_state.active_source = SRC_TERMINAL;
    end else if (s_force[1]) begin
      next_state.active_source = SRC_PANEL;
    end else if (s_force[2]) begin
      next_state.active_source = SRC_NETWORK;
    end else begin
      next_state.active_source = stored_source;
    end
    // the bank level only matters when the motor is idle, so a change during a run
    // takes effect at the next stop
    if (motor_running) begin
      next_state.bank = DDI_BANK_IDLE;
    end else begin
      next_state.bank = s_bank ? DDI_BANK_SAVE : DDI_BANK_LOAD;
    end
    next_state.control_mode_two = s_mode;
    if (s_inen && !start_active && !other_run_request && (|s_inch)) begin
      next_state.inch_start      = 1'b1;
      next_state.inch_ref_select = s_inch[0] ? 2'h1 : 2'h2;
    end else begin
      next_state.inch_start      = 1'b0;
      next_state.inch_ref_select = 2'h0;
    end
    next_state.quick_stop         = s_qs;
    next_state.supply_switch_trip = ~s_ack;
    next_state.motor_number       = {1'b0, s_motor} + 4'h1;
    case (state.link)
      DDI_LINK_DRIVE: begin
        next_state.conv_cmd = 1'b1;
        next_state.line_cmd = 1'b0;
        if (s_syncreq) next_state.link = DDI_LINK_SYNC;
      end
      DDI_LINK_SYNC: begin
        if (!s_syncreq) begin
          next_state.link = DDI_LINK_DRIVE;
        end else if (sync_complete && s_xfer) begin
          next_state.link     = DDI_LINK_DIRECT;
          next_state.line_cmd = 1'b1;
          next_state.conv_cmd = 1'b0;
        end
      end
      DDI_LINK_DIRECT: begin
        if (multi_motor_mode ? s_xrst : !s_xfer) begin
          next_state.line_cmd = 1'b0;
          next_state.conv_cmd = 1'b1;
          next_state.link     = DDI_LINK_DRIVE;
        end
      end
      default: next_state.link = DDI_LINK_DRIVE;
    endcase
    // decoded copies are registered so every output leaves a flip-flop
    next_state.ext_trip_code = next_state.ext_trip ? EXT_TRIP_CODE : 8'h00;
    next_state.bank_load     = (next_state.bank == DDI_BANK_LOAD);
    next_state.bank_save     = (next_state.bank == DDI_BANK_SAVE);
    next_state.sync_active   = (next_state.link == DDI_LINK_SYNC);
    // contactors need time to move; a mismatch must persist before tripping
    if ((s_convfb != state.conv_cmd) || (s_linefb != state.line_cmd)) begin
      if (state.fb_count >= FB_W'(FEEDBACK_DELAY)) begin
        next_state.fb_trip = 1'b1;
      end else begin
        next_state.fb_count = state.fb_count + 1'b1;
      end
    end else begin
      next_state.fb_count = '0;
      next_state.fb_trip  = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state              <= '0;
      state.preset_index <= RESET_PRESET;
      state.bank         <= DDI_BANK_IDLE;
      state.link         <= DDI_LINK_DRIVE;
      state.motor_number <= 4'h1;
    end else begin
      state <= next_state;
    end
  end

  assign preset_index       = state.preset_index;
  assign pot_decrease       = state.pot_decrease;
  assign pot_increase       = state.pot_increase;
  assign trip_clear         = state.trip_clear;
  assign ext_trip           = state.ext_trip;
  assign ext_trip_code      = state.ext_trip_code;
  assign ramp_set_two       = state.ramp_set_two;
  assign ramp_hold          = state.ramp_hold;
  assign ramp_hold_decel_ok = state.ramp_hold_decel_ok;
  assign dc_braking         = state.dc_braking;
  assign jog_select         = state.jog_select;
  assign ref_use_ai         = state.ref_use_ai;
  assign ref_alternate      = state.ref_alternate;
  assign active_source      = state.active_source;
  assign source_forced      = state.source_forced;
  assign bank_load          = state.bank_load;
  assign bank_save          = state.bank_save;
  assign control_mode_two   = state.control_mode_two;
  assign inch_start         = state.inch_start;
  assign inch_ref_select    = state.inch_ref_select;
  assign quick_stop         = state.quick_stop;
  assign supply_switch_trip = state.supply_switch_trip;
  assign sync_active        = state.sync_active;
  assign conv_contactor_cmd = state.conv_cmd;
  assign line_contactor_cmd = state.line_cmd;
  assign contactor_feedback_trip = state.fb_trip;
  assign motor_number       = state.motor_number;
endmodule : ddi_decoder

// file: ddi_decoder_monitor.sv
/*
  Port checker for the drive digital input decoder.
  Assumes pins reach outputs after 3 edges and same-clock inputs after 1 edge.
*/
`timescale 1ns/10ps
module ddi_decoder_monitor
  import ddi_pkg::*;
(
  input wire logic       clock,
  input wire logic       rst_b,
  input wire logic [2:0] preset_in,
  input wire logic       motor_select_bit0,
  input wire logic       motor_select_bit1,
  input wire logic       motor_select_bit2,
  input wire logic       trip_clear_in,
  input wire logic       ext_trip_no_in,
  input wire logic       ext_trip_nc_in,
  input wire logic       dc_braking_request,
  input wire logic       motor_stopped,
  input wire logic       settings_bank_select,
  input wire logic       motor_running,
  input wire logic [2:0] force_src_in,
  input wire logic [1:0] stored_source,
  input wire logic       supply_ack_in,
  input wire logic [2:0] preset_index,
  input wire logic [3:0] motor_number,
  input wire logic       trip_clear,
  input wire logic       ext_trip,
  input wire logic [7:0] ext_trip_code,
  input wire logic       dc_braking,
  input wire logic       bank_load,
  input wire logic       bank_save,
  input wire logic [1:0] active_source,
  input wire logic       supply_switch_trip
);
  logic [2:0] up;
  // pin history is trusted only once the synchroniser has refilled after reset
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) up <= 3'h0;
    else if (up != 3'h7) up <= up + 3'h1;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  a_preset_code: assert property (up == 3'h7 |-> preset_index == $past(preset_in, 3))
    else $error("preset index does not follow preset inputs");
  a_motor_number: assert property (up == 3'h7 |-> motor_number ==
    {1'b0, $past(motor_select_bit2, 3), $past(motor_select_bit1, 3),
     $past(motor_select_bit0, 3)} + 4'h1)
    else $error("motor number is not select code plus one");
  a_clear_on_rise: assert property (up == 3'h7 |-> trip_clear ==
    ($past(trip_clear_in, 3) && !$past(trip_clear_in, 4)))
    else $error("trip clear not tied to a rising edge");
  a_ext_trip_level: assert property (up == 3'h7 |-> ext_trip ==
    ($past(ext_trip_no_in, 3) || !$past(ext_trip_nc_in, 3)))
    else $error("external trip does not follow contacts");
  a_ext_trip_code: assert property (ext_trip_code == (ext_trip ? 8'h33 : 8'h00))
    else $error("external trip code wrong");
  a_dc_brake_stop: assert property (up == 3'h7 |-> dc_braking ==
    ($past(dc_braking_request, 3) && $past(motor_stopped)))
    else $error("dc braking outside stopped request");
  a_bank_idle_run: assert property ($past(motor_running) |-> !bank_load && !bank_save)
    else $error("bank action while running");
  a_bank_select: assert property (up == 3'h7 && !$past(motor_running) |->
    bank_save == $past(settings_bank_select, 3) && bank_load != bank_save)
    else $error("bank load or save wrong");
  a_source_priority: assert property (up == 3'h7 |-> active_source ==
    ($past(force_src_in[0], 3) ? SRC_TERMINAL : $past(force_src_in[1], 3) ? SRC_PANEL :
     $past(force_src_in[2], 3) ? SRC_NETWORK : $past(stored_source)))
    else $error("active source wrong");
  a_supply_trip: assert property (up == 3'h7 |-> supply_switch_trip == !$past(supply_ack_in, 3))
    else $error("supply switch trip wrong");
endmodule : ddi_decoder_monitor

bind ddi_decoder ddi_decoder_monitor u_ddi_decoder_monitor (.clock, .rst_b, .preset_in,
  .motor_select_bit0, .motor_select_bit1, .motor_select_bit2, .trip_clear_in, .ext_trip_no_in,
  .ext_trip_nc_in, .dc_braking_request, .motor_stopped, .settings_bank_select, .motor_running,
  .force_src_in, .stored_source, .supply_ack_in, .preset_index, .motor_number, .trip_clear,
  .ext_trip, .ext_trip_code, .dc_braking, .bank_load, .bank_save, .active_source,
  .supply_switch_trip);

// file: ddi_field_model.sv
/*
  Contactor feedback model for the far side of the decoder.
  Assumes commands come from the decoder on the same clock.
*/
`timescale 1ns/10ps
module ddi_field_model (
  input  wire logic clock,
  input  wire logic rst_b,
  input  wire logic conv_contactor_cmd,
  input  wire logic line_contactor_cmd,
  input  wire logic line_fb_fault,
  output logic      conv_contactor_fb_in,
  output logic      line_contactor_fb_in
);
  // contacts follow their coil one clock late; a fault reports the line contact inverted
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      conv_contactor_fb_in <= 1'b0;
      line_contactor_fb_in <= 1'b0;
    end else begin
      conv_contactor_fb_in <= conv_contactor_cmd;
      line_contactor_fb_in <= line_contactor_cmd ^ line_fb_fault;
    end
  end
endmodule : ddi_field_model

// file: testbench.sv
/*
  Self-checking testbench for the drive digital input decoder.
  Assumes the field model answers contactor commands; all other pins come from here.
*/
`timescale 1ns/10ps
module testbench;
  import ddi_pkg::*;
  logic clock = 1'b0, rst_b = 1'b0, line_fb_fault = 1'b0;
  logic [2:0] preset_in = 3'h0, force_src_in = 3'h0;
  logic [1:0] inch_in = 2'h0, stored_source = SRC_PANEL;
  logic [4:0] ref_selection = 5'h00;
  logic pot_down_in = 1'b0, pot_up_in = 1'b0, trip_clear_in = 1'b0, ext_trip_no_in = 1'b0;
  logic ext_trip_nc_in = 1'b1, ramp_set_in = 1'b0, ramp_hold_in = 1'b0, jog_in = 1'b0;
  logic dc_braking_request = 1'b0, ref_source_in = 1'b0, settings_bank_select = 1'b0;
  logic control_mode_select = 1'b0, inch_enable_in = 1'b0, quick_stop_in = 1'b0;
  logic supply_ack_in = 1'b1, sync_request_in = 1'b0, transfer_request_in = 1'b0;
  logic transfer_reset_in = 1'b0, motor_select_bit0 = 1'b0, motor_select_bit1 = 1'b0;
  logic motor_select_bit2 = 1'b0, hold_allows_decel_option = 1'b0, motor_running = 1'b0;
  logic motor_stopped = 1'b0, start_active = 1'b0, other_run_request = 1'b0;
  logic multi_motor_mode = 1'b0, sync_complete = 1'b0, conv_contactor_fb_in, line_contactor_fb_in;
  logic [2:0] preset_index;
  logic [7:0] ext_trip_code;
  logic [1:0] active_source, inch_ref_select;
  logic [3:0] motor_number;
  logic pot_decrease, pot_increase, trip_clear, ext_trip, ramp_set_two, ramp_hold, jog_select;
  logic ramp_hold_decel_ok, dc_braking, ref_use_ai, ref_alternate, source_forced, bank_load;
  logic bank_save, control_mode_two, inch_start, quick_stop, supply_switch_trip, sync_active;
  logic conv_contactor_cmd, line_contactor_cmd, contactor_feedback_trip;
  int n_mismatch = 0, check_count = 0, pulses;

  ddi_decoder #(.FEEDBACK_DELAY(8)) u_ddi_decoder (.clock, .rst_b, .preset_in, .pot_down_in,
    .pot_up_in, .trip_clear_in, .ext_trip_no_in, .ext_trip_nc_in, .ramp_set_in, .ramp_hold_in,
    .dc_braking_request, .jog_in, .ref_source_in, .force_src_in, .settings_bank_select,
    .control_mode_select, .inch_enable_in, .inch_in, .quick_stop_in, .supply_ack_in,
    .sync_request_in, .transfer_request_in, .transfer_reset_in, .conv_contactor_fb_in,
    .line_contactor_fb_in, .motor_select_bit0, .motor_select_bit1, .motor_select_bit2,
    .hold_allows_decel_option, .motor_running, .motor_stopped, .start_active,
    .other_run_request, .stored_source, .ref_selection, .multi_motor_mode, .sync_complete,
    .preset_index, .pot_decrease, .pot_increase, .trip_clear, .ext_trip, .ext_trip_code,
    .ramp_set_two, .ramp_hold, .ramp_hold_decel_ok, .dc_braking, .jog_select, .ref_use_ai,
    .ref_alternate, .active_source, .source_forced, .bank_load, .bank_save, .control_mode_two,
    .inch_start, .inch_ref_select, .quick_stop, .supply_switch_trip, .sync_active,
    .conv_contactor_cmd, .line_contactor_cmd, .contactor_feedback_trip, .motor_number);
  ddi_field_model u_ddi_field_model (.clock, .rst_b, .conv_contactor_cmd, .line_contactor_cmd,
    .line_fb_fault, .conv_contactor_fb_in, .line_contactor_fb_in);

  always #50 clock = ~clock;

  task automatic check(input logic [7:0] seen, input logic [7:0] expected);
    check_count++;
    if (seen !== expected) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, expected);
    end
  endtask : check
  // five edges covers the three-edge pin path with margin
  task automatic settle();
    repeat (5) @(posedge clock);
    #1;
  endtask : settle
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop
  task automatic inch_case(input logic [3:0] pins, input logic es, input logic [1:0] er);
    @(posedge clock);
    {inch_enable_in, start_active, other_run_request} <= pins[3:1];
    inch_in <= {1'b0, pins[0]} | 2'h2;
    settle();
    check(inch_start, es);
    check(inch_ref_select, er);
  endtask : inch_case

  initial begin
    #(20000 * 100);
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    settle();
    for (int i = 0; i < 8; i++) begin
      @(posedge clock);
      preset_in <= 3'(i);
      {motor_select_bit2, motor_select_bit1, motor_select_bit0} <= 3'(7 - i);
      {ext_trip_no_in, ext_trip_nc_in} <= 2'(i) ^ 2'h1;
      {pot_down_in, pot_up_in} <= 2'(i);
      {dc_braking_request, motor_stopped} <= 2'(i);
      {motor_running, settings_bank_select} <= 2'(i);
      force_src_in <= 3'(i);
      supply_ack_in <= i[0];
      settle();
      check(preset_index, 8'(i));
      check(motor_number, 8'(8 - i));
      check(ext_trip, 8'(i[1] || i[0]));
      check(ext_trip_code, (i[1] || i[0]) ? 8'h33 : 8'h00);
      check(pot_decrease, 8'(i[1]));
      check(pot_increase, 8'(i[1:0] == 2'h1));
      check(dc_braking, 8'(i[1:0] == 2'h3));
      check(bank_load, 8'(i[1:0] == 2'h0));
      check(bank_save, 8'(i[1:0] == 2'h1));
      check(active_source, i[0] ? SRC_TERMINAL : i[1] ? SRC_PANEL : i[2] ? SRC_NETWORK
            : SRC_PANEL);
      check(source_forced, 8'(i != 0));
      check(supply_switch_trip, 8'(!i[0]));
    end
    $display("test codes finished");
    for (int v = 0; v < 2; v++) begin
      @(posedge clock);
      {ramp_set_in, ramp_hold_in, hold_allows_decel_option, jog_in} <= {4{v[0]}};
      {control_mode_select, quick_stop_in, ref_source_in} <= {3{v[0]}};
      ref_selection <= v[0] ? 5'h0E : 5'h0D;
      settle();
      check({ramp_set_two, ramp_hold, ramp_hold_decel_ok, jog_select}, {4{v[0]}});
      check({control_mode_two, quick_stop, ref_alternate}, {3{v[0]}});
      check(ref_use_ai, 8'(v));
    end
    $display("test levels finished");
    @(posedge clock);
    trip_clear_in <= 1'b1;
    pulses = 0;
    repeat (10) begin
      @(posedge clock);
      #1;
      if (trip_clear === 1'b1) pulses++;
    end
    check(8'(pulses), 8'h01);
    $display("test trip clear finished");
    inch_case(4'h9, 1'b1, 2'h1);
    inch_case(4'h8, 1'b1, 2'h2);
    inch_case(4'hD, 1'b0, 2'h0);
    inch_case(4'hB, 1'b0, 2'h0);
    inch_case(4'h1, 1'b0, 2'h0);
    $display("test inching finished");
    @(posedge clock);
    {supply_ack_in, motor_stopped, motor_running, sync_request_in} <= 4'hD;
    settle();
    check(sync_active, 8'h01);
    @(posedge clock);
    {sync_complete, transfer_request_in} <= 2'h3;
    settle();
    check({sync_active, line_contactor_cmd, conv_contactor_cmd}, 8'h02);
    @(posedge clock);
    transfer_request_in <= 1'b0;
    settle();
    check({line_contactor_cmd, conv_contactor_cmd}, 8'h01);
    @(posedge clock);
    {multi_motor_mode, transfer_request_in} <= 2'h3;
    settle();
    @(posedge clock);
    transfer_request_in <= 1'b0;
    settle();
    check(line_contactor_cmd, 8'h01);
    @(posedge clock);
    transfer_reset_in <= 1'b1;
    settle();
    check({line_contactor_cmd, conv_contactor_cmd}, 8'h01);
    check(contactor_feedback_trip, 8'h00);
    $display("test transfer finished");
    @(posedge clock);
    line_fb_fault <= 1'b1;
    for (int k = 0; k < 30 && contactor_feedback_trip !== 1'b1; k++) begin
      @(posedge clock);
      #1;
    end
    check(contactor_feedback_trip, 8'h01);
    @(posedge clock);
    line_fb_fault <= 1'b0;
    settle();
    check(contactor_feedback_trip, 8'h00);
    $display("test feedback finished");
    report_and_stop();
  end
endmodule : testbench
